// ===== isprw_cfg.svh
/*
 * isprw_cfg.svh: offsets, field positions, reset values and timing counts
 * of the word programmer.
 * assumes: included by the top design module only, not by isprw_pkg.sv or the timer.
 */
`ifndef ISPRW_CFG_SVH
`define ISPRW_CFG_SVH

// ==========================================================
// register offsets
`define ISPRW_OFF_ADDR_HIGH 8'hA0
`define ISPRW_OFF_ADDR_LOW 8'hA1
`define ISPRW_OFF_DATA_HIGH 8'hA2
`define ISPRW_OFF_DATA_LOW 8'hA3
`define ISPRW_OFF_TIME_SEL 8'hA4
`define ISPRW_OFF_COMMAND 8'hA5
`define ISPRW_OFF_STATUS 8'hA6

// ==========================================================
// field positions and reset values
`define ISPRW_VREADY_BIT 7
`define ISPRW_CMD_GO_BIT 0
`define ISPRW_STAT_BUSY_BIT 0
`define ISPRW_STAT_DONE_BIT 1
`define ISPRW_STAT_REJ_BIT 2
`define ISPRW_RST_BYTE 8'h00
`define ISPRW_RST_TSEL 2'h0

// ==========================================================
// timing
`define ISPRW_CLK_MHZ 50
`define ISPRW_T240_US 240
`define ISPRW_T120_US 120
`define ISPRW_T60_US 60
`define ISPRW_T30_US 30
`define ISPRW_CYC(us) ((us) * `ISPRW_CLK_MHZ)

`endif

// ===== isprw_pkg.sv
/*
 * isprw_pkg: types of the word programmer.
 * assumes: isprw_cfg.svh sits in the include path.
 */
package isprw_pkg;

    // ======================================================
    // controller states
    typedef enum logic [1:0] {
        ISPRW_IDLE = 2'b00,
        ISPRW_PROG = 2'b01,
        ISPRW_DONE = 2'b10
    } isprw_state_t;

    // ======================================================
    // ROM write port carrier
    typedef struct packed {
        logic en;
        logic [12:0] addr;
        logic [15:0] data;
    } isprw_rom_wr_t;

endpackage : isprw_pkg

// ===== isprw_timer.sv
/*
 * isprw_timer: programming-time down counter.
 * assumes: start is a one-cycle pulse on i_mclk; load value from the top.
 */
`timescale 1ns/100ps
module isprw_timer #(
    parameter int WIDTH = 14
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // control
    input wire logic i_start,
    input wire logic [WIDTH-1:0] i_load,
    // status
    output logic o_busy,
    output logic o_expire
);
    logic [WIDTH-1:0] cnt_r;
    logic busy_r;
    wire last = busy_r && (cnt_r == WIDTH'(1));

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cnt_r <= '0;
            busy_r <= 1'b0;
        end else if (i_start) begin
            cnt_r <= i_load;
            busy_r <= 1'b1;
        end else if (busy_r) begin
            cnt_r <= cnt_r - WIDTH'(1);
            busy_r <= !last;
        end
    end

    assign o_busy = busy_r;
    assign o_expire = last;
endmodule : isprw_timer

// ===== isprw_top.sv
/*
 * isprw_top: in-system word programmer for the program ROM.
 * assumes: plain register port on i_mclk, ROM write port accepts o_rom_wr
 * as a one-cycle strobe; i_vpp_ok comes from an analogue comparator.
 */
`timescale 1ns/100ps
`include "isprw_cfg.svh"
module isprw_top
    import isprw_pkg::*;
#(
    parameter int TW = 14
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // programming voltage sense
    input wire logic i_vpp_ok,
    // program word instruction
    input wire logic i_program_word_instr,
    // rom write port and busy flag
    output isprw_rom_wr_t o_rom_wr,
    output logic o_busy
);
    // ======================================================
    // registers
    logic [4:0] addr_hi_r;
    logic [7:0] addr_lo_r;
    logic [7:0] data_hi_r;
    logic [7:0] data_lo_r;
    logic [1:0] tsel_r;
    logic done_r;
    logic rej_r;
    logic vpp_s1_r;
    logic vpp_s2_r;
    logic [7:0] rdata_r;
    isprw_state_t state_r;
    isprw_state_t state_nxt;
    isprw_rom_wr_t rom_r;
    logic [12:0] hold_addr_r;
    logic [15:0] hold_data_r;

    // ======================================================
    // decode
    wire sel_ah = i_addr == `ISPRW_OFF_ADDR_HIGH;
    wire sel_al = i_addr == `ISPRW_OFF_ADDR_LOW;
    wire sel_dh = i_addr == `ISPRW_OFF_DATA_HIGH;
    wire sel_dl = i_addr == `ISPRW_OFF_DATA_LOW;
    wire sel_ts = i_addr == `ISPRW_OFF_TIME_SEL;
    wire sel_cmd = i_addr == `ISPRW_OFF_COMMAND;
    wire sel_st = i_addr == `ISPRW_OFF_STATUS;
    wire cmd_wr = i_wr && sel_cmd && i_wdata[`ISPRW_CMD_GO_BIT];
    wire request = cmd_wr || i_program_word_instr;
    wire vready = vpp_s2_r;
    wire timer_busy;
    wire expire;
    wire accept = request && (state_r == ISPRW_IDLE) && vready;
    wire reject = request && !accept;

    // ======================================================
    // programming time select
    function automatic logic [TW-1:0] prog_cycles(input logic [1:0] sel);
        case (sel)
            2'h0: prog_cycles = TW'(`ISPRW_CYC(`ISPRW_T240_US));
            2'h1: prog_cycles = TW'(`ISPRW_CYC(`ISPRW_T120_US));
            2'h2: prog_cycles = TW'(`ISPRW_CYC(`ISPRW_T60_US));
            default: prog_cycles = TW'(`ISPRW_CYC(`ISPRW_T30_US));
        endcase
    endfunction : prog_cycles

    isprw_timer #(
        .WIDTH(TW)
    ) u_timer (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_start(accept),
        .i_load(prog_cycles(tsel_r)),
        .o_busy(timer_busy),
        .o_expire(expire)
    );

    // ======================================================
    // read mux
    wire [7:0] rd_mux =
        sel_ah ? {vready, 2'h0, addr_hi_r} :
        sel_al ? addr_lo_r :
        sel_dh ? data_hi_r :
        sel_dl ? data_lo_r :
        sel_st ? {5'h00, rej_r, done_r, timer_busy} :
        8'h00;

    // ======================================================
    // voltage flag synchroniser
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            vpp_s1_r <= 1'b0;
            vpp_s2_r <= 1'b0;
        end else begin
            vpp_s1_r <= i_vpp_ok;
            vpp_s2_r <= vpp_s1_r;
        end
    end

    // ======================================================
    // software registers
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            addr_hi_r <= 5'h00;
            addr_lo_r <= `ISPRW_RST_BYTE;
            data_hi_r <= `ISPRW_RST_BYTE;
            data_lo_r <= `ISPRW_RST_BYTE;
            tsel_r <= `ISPRW_RST_TSEL;
        end else if (i_wr) begin
            if (sel_ah) addr_hi_r <= i_wdata[4:0];
            if (sel_al) addr_lo_r <= i_wdata;
            if (sel_dh) data_hi_r <= i_wdata;
            if (sel_dl) data_lo_r <= i_wdata;
            if (sel_ts) tsel_r <= i_wdata[1:0];
        end
    end

    // ======================================================
    // read data, one cycle later
    always_ff @(posedge i_mclk) begin
        if (i_rst) rdata_r <= 8'h00;
        else rdata_r <= i_rd ? rd_mux : 8'h00;
    end

    // ======================================================
    // sticky status, set wins over clear by status read
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            done_r <= 1'b0;
            rej_r <= 1'b0;
        end else begin
            done_r <= expire || (done_r && !(i_rd && sel_st));
            rej_r <= reject || (rej_r && !(i_rd && sel_st));
        end
    end

    // ======================================================
    // controller
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ISPRW_IDLE: if (accept) state_nxt = ISPRW_PROG;
            ISPRW_PROG: if (expire) state_nxt = ISPRW_DONE;
            ISPRW_DONE: state_nxt = ISPRW_IDLE;
            default: state_nxt = ISPRW_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state_r <= ISPRW_IDLE;
            hold_addr_r <= 13'h0000;
            hold_data_r <= 16'h0000;
            rom_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (accept) begin
                hold_addr_r <= {addr_hi_r, addr_lo_r};
                hold_data_r <= {data_hi_r, data_lo_r};
            end
            rom_r.en <= expire;
            rom_r.addr <= hold_addr_r;
            rom_r.data <= hold_data_r;
        end
    end

    assign o_rdata = rdata_r;
    assign o_rom_wr = rom_r;
    assign o_busy = (state_r != ISPRW_IDLE);
endmodule : isprw_top

// ===== isprw_top_asserts.sv
/*
 * isprw_top_asserts: port checks of the word programmer.
 * assumes: bound to isprw_top; one clock, synchronous reset.
 */
`timescale 1ns/100ps
module isprw_top_asserts
    import isprw_pkg::*;
#(
    parameter int TW = 14
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // watched ports
    input wire logic [7:0] i_addr,
    input wire logic i_rd,
    input wire logic i_vpp_ok,
    input wire logic [7:0] o_rdata,
    input wire isprw_rom_wr_t o_rom_wr,
    input wire logic o_busy
);
    // ======================================================
    // busy cycle counter
    logic [13:0] cnt_r;
    always_ff @(posedge i_mclk) begin
        if (i_rst || !o_busy) begin
            cnt_r <= 14'h0000;
        end else begin
            cnt_r <= cnt_r + 14'h0001;
        end
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // ======================================================
    // sequences and properties
    sequence vpp_low_s;
        (!i_vpp_ok) [*4];
    endsequence
    sequence rd_of_s(logic [7:0] a);
        $past(i_rd) && ($past(i_addr) == a);
    endsequence
    chk_rdata_rest: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside answer");
    chk_hi_gaps: assert property (rd_of_s(8'hA0) |-> o_rdata[6:5] == 2'b00)
        else $error("address high gap bits set");
    chk_flag_high: assert property ((i_vpp_ok [*4]) ##0 rd_of_s(8'hA0)
        |-> o_rdata[7]) else $error("ready flag reads zero");
    chk_flag_low: assert property (vpp_low_s ##0 rd_of_s(8'hA0)
        |-> !o_rdata[7]) else $error("ready flag reads one");
    chk_en_single: assert property (o_rom_wr.en |=> !o_rom_wr.en)
        else $error("rom write longer than one cycle");
    chk_en_busy: assert property (o_rom_wr.en |-> o_busy ##1 !o_busy)
        else $error("busy wrong around rom write");
    chk_prog_time: assert property (o_rom_wr.en |-> cnt_r inside
        {14'h2EE0, 14'h1770, 14'h0BB8, 14'h05DC})
        else $error("programming time wrong");
    chk_wo_time: assert property (rd_of_s(8'hA4) |-> o_rdata == 8'h00)
        else $error("time select readable");
    chk_no_vpp: assert property (vpp_low_s ##1 !o_busy |=> !o_busy)
        else $error("started without ready voltage");
endmodule : isprw_top_asserts
bind isprw_top isprw_top_asserts #(.TW(TW)) u_isprw_top_asserts (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_rd(i_rd),
    .i_vpp_ok(i_vpp_ok), .o_rdata(o_rdata), .o_rom_wr(o_rom_wr),
    .o_busy(o_busy));

// ===== isprw_top_test.sv
/*
 * isprw_top_test: self-checking bench of the word programmer.
 * assumes: isprw_top with its checker bound; 50 MHz clock.
 */
`timescale 1ns/100ps
module isprw_top_test import isprw_pkg::*; ;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_vpp_ok = 1'b0;
    logic i_program_word_instr = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic [7:0] o_rdata;
    logic o_busy;
    isprw_rom_wr_t o_rom_wr;
    logic [7:0] lf = 8'h4B;
    int err_count = 0;
    int n_tests = 0;
    always #10 i_mclk = ~i_mclk;
    isprw_top #(.TW(14)) u_isprw_top (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_vpp_ok(i_vpp_ok),
        .i_program_word_instr(i_program_word_instr), .o_rom_wr(o_rom_wr),
        .o_busy(o_busy));
    // ======================================================
    // helpers
    function logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    function int cyc(input logic [1:0] c);
        return 12000 >> c;
    endfunction : cyc
    task check(input logic [29:0] seen, input logic [29:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task test_done;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 check(o_rdata, e);
    endtask : rd
    // ======================================================
    // main sequence
    initial begin : main
        logic [12:0] a;
        logic [15:0] d;
        int n;
        repeat (12) @(posedge i_mclk);
        i_rst <= 1'b0;
        for (int k = 0; k < 4; k++) rd(8'(8'hA0 + k), 8'h00);
        rd(8'hA7, 8'h00);
        @(posedge i_mclk);
        i_program_word_instr <= 1'b1;
        @(posedge i_mclk);
        i_program_word_instr <= 1'b0;
        repeat (20) @(posedge i_mclk);
        #1 check(o_busy, 30'h0);
        rd(8'hA6, 8'h04);
        @(posedge i_mclk);
        i_vpp_ok <= 1'b1;
        repeat (4) @(posedge i_mclk);
        for (int c = 0; c < 4; c++) begin
            lf = lfsr(lf);
            d[15:8] = lf;
            lf = lfsr(lf);
            d[7:0] = lf;
            lf = lfsr(lf);
            a = (c == 0) ? 13'h1FFF : {lf[4:0], d[7:0] ^ d[15:8]};
            wr(8'hA0, {3'b111, a[12:8]});
            wr(8'hA1, a[7:0]);
            wr(8'hA2, d[15:8]);
            wr(8'hA3, d[7:0]);
            wr(8'hA4, {6'h00, c[1:0]});
            rd(8'hA0, {3'b100, a[12:8]});
            rd(8'hA1, a[7:0]);
            rd(8'hA2, d[15:8]);
            rd(8'hA3, d[7:0]);
            rd(8'hA4, 8'h00);
            @(posedge i_mclk);
            i_program_word_instr <= c[0];
            i_wr <= !c[0];
            i_addr <= 8'hA5;
            i_wdata <= 8'h01;
            @(posedge i_mclk);
            i_program_word_instr <= 1'b0;
            i_wr <= 1'b0;
            n = 0;
            while (n < 13000 && o_rom_wr.en !== 1'b1) begin
                @(posedge i_mclk);
                n++;
                i_rd <= (n == 2);
                i_addr <= 8'hA6;
                i_program_word_instr <= (n == 4);
                #1;
                if (n == 3) check(o_rdata, 8'h01);
            end
            if (n == 13000) begin
                err_count++;
                test_done();
            end
            check(30'(n), 30'(cyc(c[1:0])));
            check(o_rom_wr, {1'b1, a, d});
            @(posedge i_mclk);
            #1 check(o_busy, 30'h0);
            rd(8'hA6, 8'h06);
        end
        test_done();
    end
endmodule : isprw_top_test
